// file: shared/dsw_pkg.sv
/*
  Constants shared by the deep-sleep wake controller: register offsets,
  field positions, reset values, wake-source codes and timing counts.
  Assumes a 200 MHz system clock and an AHB-Lite register bus.
*/
package dsw_pkg;
  // ===========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_WDT_CONTROL = 8'h04;
  localparam logic [7:0] OFF_WAKE_LOW = 8'h08;
  localparam logic [7:0] OFF_WAKE_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // ===========================================================
  // Configuration field positions
  localparam int CFG_WDT_CLK_BIT = 0;
  localparam int CFG_CAL_CLK_BIT = 1;
  localparam int CFG_BOR_EN_BIT = 2;
  localparam int CFG_WDT_EN_BIT = 3;
  localparam int CFG_PS_LSB = 4;
  localparam int CFG_PS_MSB = 7;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  // Watchdog control register: exit flag position.
  localparam int EXIT_FLAG_BIT = 3;
  // Control register: bit 0 requests deep-sleep entry.
  localparam int CTL_SLEEP_BIT = 0;
  // ===========================================================
  // Wake sources, one bit each, in priority order (bit 0 highest)
  localparam int NUM_SRC = 6;
  localparam int SRC_EXT_RESET = 0;
  localparam int SRC_POWER_ON = 1;
  localparam int SRC_CALENDAR = 2;
  localparam int SRC_EXT_INT = 3;
  localparam int SRC_WATCHDOG = 4;
  localparam int SRC_ULP_WAKE = 5;
  // Low status holds sources 0..4, high status holds source 5 at bit 0.
  localparam int LOW_SRC_COUNT = 5;
  // Interrupt status bits.
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // ===========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int POR_HOLD_NS = 100;
  localparam int POR_HOLD_CYC = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int WDT_WIDTH = 32;
  localparam int PS_BASE_SHIFT = 5;
endpackage

// file: hw/wake_first_latch.sv
/*
  Priority latch for the first wake source to assert while armed.
  Assumes the inputs are synchronous to CLK and armed only once deep
  sleep is fully entered.
*/
`timescale 1ns/1ps
module wake_first_latch
  import dsw_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Control
  input wire logic arm,
  input wire logic clear,
  input wire logic [N-1:0] events,
  // Result
  output logic [N-1:0] latched,
  output logic hit
);
  logic [N-1:0] latched_reg;
  logic [N-1:0] pick;

  // ===========================================================
  // Lowest index wins when several assert together.
  always_comb begin
    pick = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (events[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || clear) begin
      latched_reg <= '0; // RULE_06
    end else if (arm && latched_reg == '0) begin
      latched_reg <= pick; // RULE_10 RULE_19 RULE_07
    end
  end

  assign latched = latched_reg;
  assign hit = |latched_reg;

  a_one_hot_log: assert property (@(posedge CLK) disable iff (RST) $onehot0(latched_reg)) // RULE_19
    else $error("more than one wake source logged");
  a_first_holds: assert property (@(posedge CLK) disable iff (RST) // RULE_10
    (hit && !clear) |=> $stable(latched_reg))
    else $error("later wake source overwrote the first");
  a_no_log_unarmed: assert property (@(posedge CLK) disable iff (RST) // RULE_07
    (!arm && !hit) |=> !hit)
    else $error("wake source logged while not in deep sleep");
endmodule

// file: hw/deep_wdt.sv
/*
  Deep-sleep watchdog counter with a selectable postscaler.
  Assumes the tick input is a one-cycle pulse from the chosen slow clock.
*/
`timescale 1ns/1ps
module deep_wdt
  import dsw_pkg::*;
#(
  parameter int W = WDT_WIDTH,
  parameter int BASE = PS_BASE_SHIFT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Control
  input wire logic enable,
  input wire logic restart,
  input wire logic tick,
  input wire logic [3:0] scale,
  // Result
  output logic timeout
);
  logic [W-1:0] count_reg;
  logic timeout_reg;
  logic [W-1:0] limit;

  // Each postscale step quadruples the period; settings above 13 need more than W bits and truncate to all ones.
  assign limit = W'((64'd1 << (BASE + 32'(scale) * 2)) - 64'd1);

  always_ff @(posedge CLK) begin
    if (RST || restart || !enable) begin
      count_reg <= '0; // RULE_15 RULE_14
    end else if (tick && count_reg != limit) begin
      count_reg <= count_reg + W'(1); // RULE_11
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || restart || !enable) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= (count_reg == limit); // RULE_11
    end
  end

  assign timeout = timeout_reg;

  a_wdt_off_quiet: assert property (@(posedge CLK) disable iff (RST) // RULE_14
    !enable |=> (count_reg == '0 && !timeout))
    else $error("watchdog counted while disabled");
  a_wdt_restart: assert property (@(posedge CLK) disable iff (RST) // RULE_15
    restart |=> count_reg == '0)
    else $error("watchdog count not cleared on entry");
endmodule

// file: hw/deep_sleep_wake_control.sv
/*
  Deep-sleep wake controller: enters deep sleep on request, watches six
  wake sources once fully asleep, logs the first, forces a power-on reset
  on exit and holds the deep-sleep watchdog and brown-out enable.
  Assumes AHB-Lite single-word transfers and slow clock ticks from pins.
*/
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
// What this block does
// [RULE_01] Six events end deep sleep.
// [RULE_02] Any wake forces power-on reset, then vector.
// [RULE_03] Exit flag at watchdog control bit 3.
// [RULE_04] Only software clears the exit flag.
// [RULE_05] Wake source readable in high/low registers.
// [RULE_06] Entry clears both wake-source registers.
// [RULE_07] Log wakes only when fully asleep.
// [RULE_08] Early wake interrupt may abort entry.
// [RULE_09] Software handler follows the sleep instruction.
// [RULE_10] Only the first wake source is logged.
// [RULE_11] Watchdog postscale from config bits 7:4.
// [RULE_12] Watchdog clock chosen by config bit 0.
// [RULE_13] Software enables secondary oscillator before sleep.
// [RULE_14] Watchdog runs only with config bit 3.
// [RULE_15] Entry restarts the watchdog count.
// [RULE_16] Brown-out detector active with config bit 2.
// [RULE_17] Calendar keeps running; alarm wakes device.
// [RULE_18] Calendar clock chosen by config bit 1.
// [RULE_19] Simultaneous wakes log one by priority.
`timescale 1ns/1ps
module deep_sleep_wake_control
  import dsw_pkg::*;
#(
  parameter int HOLD_CYC = POR_HOLD_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Wake source pins, asynchronous
  input wire logic EXT_RESET_PIN_N,
  input wire logic POWER_ON_EVENT,
  input wire logic CALENDAR_ALARM,
  input wire logic EXT_INT_PIN,
  input wire logic ULTRA_LOW_POWER_WAKE,
  // Slow clock ticks, asynchronous
  input wire logic RC_OSC_TICK,
  input wire logic SECONDARY_OSC_TICK,
  // Power control
  output logic DEEP_SLEEP,
  output logic POR_REQUEST,
  output logic BROWNOUT_ENABLE,
  output logic CALENDAR_CLK_SEL,
  output logic CALENDAR_TICK,
  output logic IRQ
);
  typedef enum logic [1:0] {S_RUN, S_SLEEP, S_RESET} state_e;
  state_e state_reg, state_next;

  logic [6:0] sync1_reg, sync2_reg;
  logic rc_last_reg, sec_last_reg;
  logic [7:0] config_reg;
  logic exit_flag_reg;
  logic sleep_req_reg;
  logic [IRQ_WIDTH-1:0] irq_status_reg, irq_mask_reg;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [$clog2(HOLD_CYC+1)-1:0] hold_reg;
  logic [NUM_SRC-1:0] wake_events, wake_log;
  logic wake_hit, wdt_timeout, wdt_tick, entering;
  logic ph_valid_reg, ph_write_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_value;
  logic early_wake;
  logic rc_edge, sec_edge;

  // ===========================================================
  // Pin synchronisers
  // The reset pin's stage resets to its idle high level, so no false wake follows reset.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_reg <= 7'h01;
      sync2_reg <= 7'h01;
    end else begin
      sync1_reg <= {SECONDARY_OSC_TICK, RC_OSC_TICK, ULTRA_LOW_POWER_WAKE, EXT_INT_PIN,
                    CALENDAR_ALARM, POWER_ON_EVENT, EXT_RESET_PIN_N};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rc_last_reg <= 1'b0;
      sec_last_reg <= 1'b0;
    end else begin
      rc_last_reg <= sync2_reg[5];
      sec_last_reg <= sync2_reg[6];
    end
  end

  // One edge selector serves both consumers, so the watchdog and the calendar
  // see exactly the same tick for the same clock choice.
  function automatic logic pick_tick(input logic use_sec, input logic sec_rise,
                                     input logic rc_rise);
    return use_sec ? sec_rise : rc_rise;
  endfunction

  assign sec_edge = sync2_reg[6] && !sec_last_reg;
  assign rc_edge = sync2_reg[5] && !rc_last_reg;

  // The calendar keeps its tick in every state.
  assign wdt_tick = pick_tick(config_reg[CFG_WDT_CLK_BIT], sec_edge, rc_edge); // RULE_12
  assign CALENDAR_TICK = pick_tick(config_reg[CFG_CAL_CLK_BIT],
                                   sec_edge, rc_edge); // RULE_17 RULE_18
  assign CALENDAR_CLK_SEL = config_reg[CFG_CAL_CLK_BIT]; // RULE_18

  always_comb begin
    wake_events = '0;
    wake_events[SRC_EXT_RESET] = !sync2_reg[0]; // RULE_01
    wake_events[SRC_POWER_ON] = sync2_reg[1];
    wake_events[SRC_CALENDAR] = sync2_reg[2]; // RULE_17
    wake_events[SRC_EXT_INT] = sync2_reg[3];
    wake_events[SRC_WATCHDOG] = wdt_timeout;
    wake_events[SRC_ULP_WAKE] = sync2_reg[4];
  end

  // ===========================================================
  // Sleep state machine
  assign early_wake = |wake_events;
  assign entering = (state_reg == S_RUN) && sleep_req_reg && !early_wake;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_RUN: begin
        if (entering) begin
          state_next = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (wake_hit) begin
          state_next = S_RESET; // RULE_01 RULE_02
        end
      end
      S_RESET: begin
        if (hold_reg == '0) begin
          state_next = S_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= S_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reloaded outside S_RESET, so every forced reset lasts exactly HOLD_CYC cycles.
  always_ff @(posedge CLK) begin
    if (RST || state_reg != S_RESET) begin
      hold_reg <= ($clog2(HOLD_CYC+1))'(HOLD_CYC - 1);
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - 1'b1;
    end
  end

  assign DEEP_SLEEP = (state_reg == S_SLEEP);
  assign POR_REQUEST = (state_reg == S_RESET); // RULE_02
  assign BROWNOUT_ENABLE = config_reg[CFG_BOR_EN_BIT] && DEEP_SLEEP; // RULE_16

  wake_first_latch #(.N(NUM_SRC)) u_latch (
    .CLK(CLK),
    .RST(RST),
    .arm(DEEP_SLEEP),
    .clear(entering),
    .events(wake_events),
    .latched(wake_log),
    .hit(wake_hit)
  );

  deep_wdt u_wdt (
    .CLK(CLK),
    .RST(RST),
    .enable(config_reg[CFG_WDT_EN_BIT] && DEEP_SLEEP), // RULE_14
    .restart(entering), // RULE_15
    .tick(wdt_tick),
    .scale(config_reg[CFG_PS_MSB:CFG_PS_LSB]), // RULE_11
    .timeout(wdt_timeout)
  );

  // ===========================================================
  // AHB-Lite slave, zero wait states
  // Read data is registered at the address phase, which keeps the output path short.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (HREADY) begin
      ph_valid_reg <= HSEL && HTRANS[1];
      ph_write_reg <= HWRITE;
      ph_addr_reg <= HADDR[7:0];
    end
  end

  wire wr_en = ph_valid_reg && ph_write_reg;
  wire rd_take = HSEL && HTRANS[1] && !HWRITE && HREADY;

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (HADDR[7:0])
      OFF_CONFIG: rd_value[7:0] = config_reg;
      OFF_WDT_CONTROL: rd_value[EXIT_FLAG_BIT] = exit_flag_reg; // RULE_03
      OFF_WAKE_LOW: rd_value[LOW_SRC_COUNT-1:0] = wake_log[LOW_SRC_COUNT-1:0]; // RULE_05
      OFF_WAKE_HIGH: rd_value[0] = wake_log[SRC_ULP_WAKE]; // RULE_05
      OFF_CONTROL: rd_value[CTL_SLEEP_BIT] = sleep_req_reg;
      OFF_IRQ_STATUS: rd_value[IRQ_WIDTH-1:0] = irq_status_reg;
      OFF_IRQ_MASK: rd_value[IRQ_WIDTH-1:0] = irq_mask_reg;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rd_value;
    end
  end

  assign HRDATA = rdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Configuration is writable here; a fuse loader would drive it in silicon.
  always_ff @(posedge CLK) begin
    if (RST) begin
      config_reg <= CFG_RESET;
    end else if (wr_en && ph_addr_reg == OFF_CONFIG) begin
      config_reg <= HWDATA[7:0];
    end
  end

  // Software writes bit 0 to request entry; hardware drops it on entry or abort.
  always_ff @(posedge CLK) begin
    if (RST || state_reg != S_RUN) begin
      sleep_req_reg <= 1'b0;
    end else if (wr_en && ph_addr_reg == OFF_CONTROL) begin
      sleep_req_reg <= HWDATA[CTL_SLEEP_BIT];
    end else if (sleep_req_reg && early_wake) begin
      sleep_req_reg <= 1'b0; // RULE_08
    end
  end

  // The exit flag survives the forced reset; only RST (a true cold start) and
  // software clear it, and the set wins over a simultaneous clear.
  always_ff @(posedge CLK) begin
    if (RST) begin
      exit_flag_reg <= 1'b0;
    end else if (state_reg == S_SLEEP && wake_hit) begin
      exit_flag_reg <= 1'b1; // RULE_03
    end else if (wr_en && ph_addr_reg == OFF_WDT_CONTROL && !HWDATA[EXIT_FLAG_BIT]) begin
      exit_flag_reg <= 1'b0; // RULE_04
    end
  end

  // ===========================================================
  // Interrupts: sticky status, cleared by a read, set wins.
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_WAKE_BIT] = (state_reg == S_SLEEP) && wake_hit;
    irq_set[IRQ_ABORT_BIT] = sleep_req_reg && early_wake && state_reg == S_RUN; // RULE_08
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_status_reg <= '0;
    end else if (rd_take && HADDR[7:0] == OFF_IRQ_STATUS) begin
      irq_status_reg <= irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_mask_reg <= '0;
    end else if (wr_en && ph_addr_reg == OFF_IRQ_MASK) begin
      irq_mask_reg <= HWDATA[IRQ_WIDTH-1:0];
    end
  end

  assign IRQ = |(irq_status_reg & irq_mask_reg);

  // ===========================================================
  // Checks
  a_wake_to_reset: assert property (@(posedge CLK) disable iff (RST) // RULE_02
    (DEEP_SLEEP && wake_hit) |=> POR_REQUEST)
    else $error("wake did not force a reset");
  a_reset_length: assert property (@(posedge CLK) disable iff (RST) // RULE_02
    $rose(POR_REQUEST) |-> POR_REQUEST [*1] ##[0:300] !POR_REQUEST)
    else $error("reset request too long");
  a_exit_flag_set: assert property (@(posedge CLK) disable iff (RST) // RULE_03
    $rose(POR_REQUEST) |-> exit_flag_reg)
    else $error("exit flag not set on wake");
  a_exit_flag_cause: assert property (@(posedge CLK) disable iff (RST) // RULE_03
    $rose(exit_flag_reg) |-> POR_REQUEST)
    else $error("exit flag set without a deep-sleep wake");
  a_exit_flag_sticky: assert property (@(posedge CLK) disable iff (RST) // RULE_04
    (exit_flag_reg && !(wr_en && ph_addr_reg == OFF_WDT_CONTROL)) |=> exit_flag_reg)
    else $error("exit flag cleared without software");
  a_entry_clears_log: assert property (@(posedge CLK) disable iff (RST) // RULE_06
    entering |=> (wake_log == '0))
    else $error("wake log not cleared on entry");
  a_entry_sleeps: assert property (@(posedge CLK) disable iff (RST) // RULE_07
    entering |=> DEEP_SLEEP)
    else $error("entry did not reach deep sleep");
  a_wake_logged: assert property (@(posedge CLK) disable iff (RST) // RULE_01
    (DEEP_SLEEP && !wake_hit && early_wake) |=> wake_hit)
    else $error("wake event in deep sleep not logged");
  a_early_abort: assert property (@(posedge CLK) disable iff (RST) // RULE_08
    (state_reg == S_RUN && early_wake) |=> state_reg == S_RUN)
    else $error("entered deep sleep despite early wake");
  a_abort_status: assert property (@(posedge CLK) disable iff (RST) // RULE_08
    (state_reg == S_RUN && sleep_req_reg && early_wake) |=> irq_status_reg[IRQ_ABORT_BIT])
    else $error("aborted entry not flagged");
  a_bor_gate: assert property (@(posedge CLK) disable iff (RST) // RULE_16
    BROWNOUT_ENABLE |-> (config_reg[CFG_BOR_EN_BIT] && DEEP_SLEEP))
    else $error("brown-out active while disabled");
  a_irq_sticky: assert property (@(posedge CLK) disable iff (RST)
    (irq_status_reg[IRQ_WAKE_BIT] && !(rd_take && HADDR[7:0] == OFF_IRQ_STATUS))
      |=> irq_status_reg[IRQ_WAKE_BIT])
    else $error("wake interrupt status lost without a read");
endmodule

// file: verif/tb_deep_sleep_wake_control.sv
/*
  Self-checking bench for the deep-sleep wake controller: register table,
  early-wake abort, every wake source, first-wins logging, watchdog timing.
  Assumes dsw_pkg is compiled first and that the bench is the only master.
*/
`timescale 1ns/1ps
module tb_deep_sleep_wake_control
  import dsw_pkg::*;
;
  // ==========================================================
  // Signals
  localparam int HOLD = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [5:0] src = 6'h0;
  logic rc_tick = 1'b0;
  logic sec_tick = 1'b0;
  logic ds, por, brown, cal_sel, cal_tick, irq;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_compared = 0;
  int cal_cnt = 0;
  int c;

  always #2.5 clk = ~clk;

  // Outputs are sampled at the rising edge, before that edge's updates land.
  always @(posedge clk) if (cal_tick === 1'b1) cal_cnt++;

  deep_sleep_wake_control #(.HOLD_CYC(HOLD)) DUT (
    .CLK(clk), .RST(rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp),
    .EXT_RESET_PIN_N(~src[SRC_EXT_RESET]), .POWER_ON_EVENT(src[SRC_POWER_ON]),
    .CALENDAR_ALARM(src[SRC_CALENDAR]), .EXT_INT_PIN(src[SRC_EXT_INT]),
    .ULTRA_LOW_POWER_WAKE(src[SRC_ULP_WAKE]),
    .RC_OSC_TICK(rc_tick), .SECONDARY_OSC_TICK(sec_tick),
    .DEEP_SLEEP(ds), .POR_REQUEST(por), .BROWNOUT_ENABLE(brown),
    .CALENDAR_CLK_SEL(cal_sel), .CALENDAR_TICK(cal_tick), .IRQ(irq)
  );

  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One single-word transfer; entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("response", 32'h0, 32'(hresp));
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  // Slow clock edges stand far apart so the two-flop synchronisers see each.
  task automatic ticks(input logic sec, input int n);
    repeat (n) begin
      if (sec) sec_tick <= 1'b1;
      else rc_tick <= 1'b1;
      cyc(3);
      sec_tick <= 1'b0;
      rc_tick <= 1'b0;
      cyc(3);
    end
  endtask

  task automatic enter_sleep(input logic [7:0] cfg);
    int n = 0;
    bus(1'b1, OFF_CONFIG, {24'h0, cfg});
    bus(1'b1, OFF_CONTROL, 32'h1);
    while (ds !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("asleep", 32'h1, 32'(ds));
    chk("brownout", 32'(cfg[CFG_BOR_EN_BIT]), 32'(brown));
    chk("cal_sel", 32'(cfg[CFG_CAL_CLK_BIT]), 32'(cal_sel));
    rchk("wake_low_clr", OFF_WAKE_LOW, 32'h0);
    rchk("wake_high_clr", OFF_WAKE_HIGH, 32'h0);
  endtask

  task automatic finish_wake(input logic [31:0] lo, input logic [31:0] hi);
    int n = 0;
    while (por !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("reset_request", 32'h1, 32'(por));
    n = 0;
    while (por === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("reset_hold", 32'(HOLD), 32'(n));
    src <= 6'h0;
    chk("awake", 32'h0, 32'(ds));
    chk("irq_wake", 32'h1, 32'(irq));
    rchk("wake_low", OFF_WAKE_LOW, lo);
    rchk("wake_high", OFF_WAKE_HIGH, hi);
    rchk("exit_flag", OFF_WDT_CONTROL, 32'h8);
    bus(1'b1, OFF_WDT_CONTROL, 32'h8);
    rchk("exit_keep", OFF_WDT_CONTROL, 32'h8);
    bus(1'b1, OFF_WDT_CONTROL, 32'h0);
    rchk("exit_clr", OFF_WDT_CONTROL, 32'h0);
    rchk("irq_status", OFF_IRQ_STATUS, 32'h1);
    cyc(2);
    chk("irq_clr", 32'h0, 32'(irq));
  endtask

  // ==========================================================
  // Register table rows
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } reg_row_s;
  reg_row_s rows [11] = '{
    '{1'b0, OFF_CONFIG, 32'h0, 32'hFF},
    '{1'b0, OFF_WDT_CONTROL, 32'h0, 32'h0},
    '{1'b0, OFF_WAKE_LOW, 32'h0, 32'h0},
    '{1'b0, OFF_WAKE_HIGH, 32'h0, 32'h0},
    '{1'b0, OFF_CONTROL, 32'h0, 32'h0},
    '{1'b0, OFF_IRQ_STATUS, 32'h0, 32'h0},
    '{1'b0, OFF_IRQ_MASK, 32'h0, 32'h0},
    '{1'b1, OFF_IRQ_MASK, 32'h3, 32'h3},
    '{1'b1, OFF_CONFIG, 32'h5E, 32'h5E},
    '{1'b1, OFF_WAKE_LOW, 32'h1F, 32'h0},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h0}
  };

  // ==========================================================
  // Main sequence
  initial begin
    cyc(2);
    rst <= 1'b0;
    chk("reset_outputs", 32'h1, {27'h0, ds, por, irq, brown, cal_sel});
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].wd);
      rchk("register", rows[i].a, rows[i].exp);
    end
    chk("cal_sel_cfg", 32'h1, 32'(cal_sel));
    chk("brownout_awake", 32'h0, 32'(brown));
    // An event that is already up when sleep is requested must abort entry.
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    src[SRC_EXT_INT] <= 1'b1;
    cyc(4);
    bus(1'b1, OFF_CONTROL, 32'h1);
    cyc(10);
    chk("abort_sleep", 32'h0, 32'(ds));
    chk("abort_irq_masked", 32'h0, 32'(irq));
    rchk("abort_status", OFF_IRQ_STATUS, 32'h2);
    rchk("early_log", OFF_WAKE_LOW, 32'h0);
    rchk("control_drop", OFF_CONTROL, 32'h0);
    // Software services the early event here and then retries entry.
    src <= 6'h0;
    cyc(4);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == SRC_WATCHDOG) continue;
      enter_sleep(8'h06);
      src[i] <= 1'b1;
      finish_wake(i < LOW_SRC_COUNT ? 32'h1 << i : 32'h0, 32'(i == SRC_ULP_WAKE));
    end
    enter_sleep(8'h06);
    src <= 6'h0C;
    finish_wake(32'h4, 32'h0);
    enter_sleep(8'h06);
    src <= 6'h20;
    cyc(1);
    src <= 6'h21;
    finish_wake(32'h0, 32'h1);
    // A partial count left from this sleep would end the next one early.
    enter_sleep(8'h09);
    ticks(1'b1, 20);
    src[SRC_EXT_INT] <= 1'b1;
    finish_wake(32'h8, 32'h0);
    enter_sleep(8'h19);
    c = cal_cnt;
    ticks(1'b0, 40);
    cyc(4);
    chk("calendar_ticks", 32'd40, 32'(cal_cnt - c));
    ticks(1'b1, 126);
    cyc(8);
    chk("wdt_early", 32'h1, 32'(ds));
    chk("calendar_src", 32'd40, 32'(cal_cnt - c));
    ticks(1'b1, 1);
    finish_wake(32'h10, 32'h0);
    // Watchdog on the RC clock; secondary edges now feed only the calendar.
    enter_sleep(8'h0A);
    c = cal_cnt;
    ticks(1'b1, 40);
    ticks(1'b0, 30);
    cyc(8);
    chk("wdt_rc_early", 32'h1, 32'(ds));
    chk("calendar_sec", 32'd40, 32'(cal_cnt - c));
    ticks(1'b0, 1);
    finish_wake(32'h10, 32'h0);
    enter_sleep(8'h11);
    ticks(1'b1, 130);
    cyc(8);
    chk("wdt_off", 32'h1, 32'(ds));
    src[SRC_ULP_WAKE] <= 1'b1;
    finish_wake(32'h0, 32'h1);
    // A cold reset in deep sleep must drop sleep and restore the registers.
    enter_sleep(8'h06);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    chk("midrun_outputs", 32'h1, {27'h0, ds, por, irq, brown, cal_sel});
    rchk("midrun_config", OFF_CONFIG, 32'hFF);
    rchk("midrun_mask", OFF_IRQ_MASK, 32'h0);
    rchk("midrun_exit", OFF_WDT_CONTROL, 32'h0);
    stop_test();
  end

  // The full run needs about 3000 cycles; this leaves ample margin.
  initial begin
    cyc(20000);
    error_cnt++;
    stop_test();
  end
endmodule
